// ### hdl/pcie_device_control_status.sv
// Device control and status registers of the endpoint capability structure
`timescale 1ns/1ns
`default_nettype none
module pcie_device_control_status
	import devctl_pkg::*;
#(
	parameter logic [2:0] MPS_CAP = devctl_pkg::MPS_CAP_DEFAULT
) (
	// Clock and power-good reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	// Ordinary (non power-good) reset, same clock
	input  wire logic                  link_reset_i,
	// Configuration access
	input  wire devctl_pkg::cfg_req_s  cfg_req_i,
	output logic                       cfg_ack_o,
	output logic [31:0]                cfg_rdata_o,
	// Events and state from the core
	input  wire devctl_pkg::err_s      err_detect_i,
	input  wire logic                  pending_i,
	input  wire logic                  relaxed_order_disable_i,
	input  wire logic [1:0]            nosnoop_gate_bits_i,
	input  wire logic                  rx_valid_i,
	input  wire logic [12:0]           rx_len_i,
	// Strap pin
	input  wire logic                  aux_power_strap_i,
	// Controls to the core
	output devctl_pkg::ctrl_s          ctrl_o,
	output logic                       relaxed_order_ok_o,
	output logic [1:0]                 nosnoop_ok_o,
	output logic                       flr_o,
	output devctl_pkg::err_s           err_msg_o,
	output logic                       rx_oversize_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ctrl_s       ctrl;
		err_s        err_sts;
		logic        aux_det;
		logic        pending;
		logic        ack;
		logic [31:0] rdata;
		logic        flr;
		err_s        msg;
		logic        ro_ok;
		logic [1:0]  ns_ok;
		logic        rx_over;
	} state_s;

	state_s s;
	state_s next_s;
	logic   strap_sync;

	// Strap comes from a pin, so it is synchronised first
	level_sync #(
		.WIDTH (1)
	) u_strap_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.async_i   (aux_power_strap_i),
		.sync_o    (strap_sync)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Control register as software sees it
	function automatic logic [15:0] ctrl_view(input ctrl_s c);
		logic [15:0] v;
		v = 16'h0000;
		v[CTL_ERR_LO +: 4]  = c.err_rep;
		v[CTL_RO_EN]        = c.ro_en;
		v[CTL_MPS_LO +: 3]  = c.mps;
		v[CTL_EXT_TAG]      = 1'b0;
		v[CTL_PHANTOM]      = 1'b0;
		v[CTL_AUX_PM]       = c.aux_pm;
		v[CTL_NOSNOOP]      = c.nosnoop_en;
		v[CTL_MRRS_LO +: 3] = c.mrrs;
		v[CTL_FLR]          = 1'b0;
		return v;
	endfunction

	// Payload size in bytes for a size code
	function automatic logic [13:0] code_bytes(input logic [2:0] code);
		return 14'(14'h0001 << (SIZE_BASE_SHIFT + int'(code)));
	endfunction

	// Register bit order puts correctable at bit 0, the struct puts it on top
	function automatic err_s err_from_bits(input logic [3:0] b);
		err_s e;
		e.corr     = b[0];
		e.nonfatal = b[1];
		e.fatal    = b[2];
		e.unsup    = b[3];
		return e;
	endfunction

	// Inverse of the above, for the read path
	function automatic logic [3:0] err_to_bits(input err_s e);
		return {e.unsup, e.fatal, e.nonfatal, e.corr};
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic        hit;
	logic        wr;
	logic [15:0] wctl;
	logic [15:0] wsts;
	logic        soft_rst;

	always_comb begin
		next_s   = s;
		hit      = cfg_req_i.valid && (cfg_req_i.addr == DEVCTL_DWORD_ADDR);
		wr       = hit && cfg_req_i.write;
		wctl     = cfg_req_i.data[15:0];
		wsts     = cfg_req_i.data[31:16];
		// Ordinary reset or a function reset started last cycle
		soft_rst = link_reset_i || s.flr;

		// Register writes, byte lane by byte lane
		if (wr && cfg_req_i.be[0]) begin
			next_s.ctrl.err_rep = wctl[CTL_ERR_LO +: 4];
			next_s.ctrl.ro_en   = wctl[CTL_RO_EN];
			// Oversized codes are dropped, not clipped
			if (wctl[CTL_MPS_LO +: 3] <= MPS_CAP) begin
				next_s.ctrl.mps = wctl[CTL_MPS_LO +: 3];
			end
		end
		if (wr && cfg_req_i.be[1]) begin
			next_s.ctrl.aux_pm     = wctl[CTL_AUX_PM];
			next_s.ctrl.nosnoop_en = wctl[CTL_NOSNOOP];
			// Reserved read-request codes leave the field unchanged
			if (wctl[CTL_MRRS_LO +: 3] <= MRRS_MAX_CODE) begin
				next_s.ctrl.mrrs = wctl[CTL_MRRS_LO +: 3];
			end
		end
		next_s.flr = wr && cfg_req_i.be[1] && wctl[CTL_FLR];

		// Error flags: set beats a simultaneous write-one clear
		next_s.err_sts = s.err_sts;
		if (wr && cfg_req_i.be[2]) begin
			next_s.err_sts = s.err_sts & ~err_from_bits(wsts[STS_ERR_LO +: 4]);
		end
		next_s.err_sts = next_s.err_sts | err_detect_i;

		// Function reset and ordinary reset clear non-sticky fields; payload size is cleared by ordinary reset only
		if (soft_rst) begin
			next_s.ctrl.err_rep    = ERR_REP_RESET;
			next_s.ctrl.ro_en      = RO_EN_RESET;
			next_s.ctrl.nosnoop_en = NOSNOOP_RESET;
			next_s.ctrl.mrrs       = MRRS_RESET;
			next_s.err_sts         = err_detect_i;
		end
		if (link_reset_i) begin
			next_s.ctrl.mps = MPS_RESET;
		end

		// Strap and pending mirror their sources
		next_s.aux_det = strap_sync;
		next_s.pending = pending_i;

		// Messages only for enabled categories
		next_s.msg = err_detect_i & err_from_bits(s.ctrl.err_rep);

		// Attribute permissions
		next_s.ro_ok = s.ctrl.ro_en && !relaxed_order_disable_i;
		next_s.ns_ok = {2{s.ctrl.nosnoop_en}} & nosnoop_gate_bits_i;

		// Received payload check against the programmed size
		next_s.rx_over = rx_valid_i && ({1'b0, rx_len_i} > code_bytes(s.ctrl.mps));

		// Read path, unmapped addresses read zero
		next_s.ack   = cfg_req_i.valid;
		next_s.rdata = 32'h0000_0000;
		if (hit && !cfg_req_i.write) begin
			next_s.rdata[15:0]                 = ctrl_view(s.ctrl);
			next_s.rdata[16 + STS_ERR_LO +: 4] = err_to_bits(s.err_sts);
			next_s.rdata[16 + STS_AUX_DET]     = s.aux_det;
			next_s.rdata[16 + STS_PENDING]     = s.pending;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Power-good reset restores everything, sticky bits included
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s                 <= '0;
			s.ctrl.err_rep    <= ERR_REP_RESET;
			s.ctrl.ro_en      <= RO_EN_RESET;
			s.ctrl.mps        <= MPS_RESET;
			s.ctrl.aux_pm     <= AUX_PM_RESET;
			s.ctrl.nosnoop_en <= NOSNOOP_RESET;
			s.ctrl.mrrs       <= MRRS_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from flops
	assign cfg_ack_o          = s.ack;
	assign cfg_rdata_o        = s.rdata;
	assign ctrl_o             = s.ctrl;
	assign relaxed_order_ok_o = s.ro_ok;
	assign nosnoop_ok_o       = s.ns_ok;
	assign flr_o              = s.flr;
	assign err_msg_o          = s.msg;
	assign rx_oversize_o      = s.rx_over;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_err_rep_written;
		@(posedge ref_clk_i) disable iff (rst_i)
		(wr && cfg_req_i.be[0] && !link_reset_i && !s.flr)
			|=> (s.ctrl.err_rep == $past(cfg_req_i.data[3:0]));
	endproperty
	a_err_rep_written: assert property (p_err_rep_written) else $error("enable write lost");

	property p_ro_perm;
		@(posedge ref_clk_i) disable iff (rst_i)
		(!s.ctrl.ro_en) |=> !s.ro_ok;
	endproperty
	a_ro_perm: assert property (p_ro_perm) else $error("relaxed order without enable");

	property p_mps_bound;
		@(posedge ref_clk_i) disable iff (rst_i)
		s.ctrl.mps <= MPS_CAP;
	endproperty
	a_mps_bound: assert property (p_mps_bound) else $error("payload code above capability");

	property p_mps_kept_flr;
		@(posedge ref_clk_i) disable iff (rst_i)
		(s.flr && !link_reset_i && !cfg_req_i.valid) |=> $stable(s.ctrl.mps);
	endproperty
	a_mps_kept_flr: assert property (p_mps_kept_flr) else $error("payload lost on function reset");

	property p_ctl_ro_zero;
		@(posedge ref_clk_i) disable iff (rst_i)
		s.ack |-> (s.rdata[CTL_EXT_TAG] == 1'b0) && (s.rdata[CTL_PHANTOM] == 1'b0)
			&& (s.rdata[CTL_FLR] == 1'b0);
	endproperty
	a_ctl_ro_zero: assert property (p_ctl_ro_zero) else $error("read-only zero bit set");

	property p_mrrs_legal;
		@(posedge ref_clk_i) disable iff (rst_i)
		s.ctrl.mrrs <= MRRS_MAX_CODE;
	endproperty
	a_mrrs_legal: assert property (p_mrrs_legal) else $error("reserved read size held");

	property p_flr_pulse;
		@(posedge ref_clk_i) disable iff (rst_i)
		(wr && cfg_req_i.be[1] && cfg_req_i.data[CTL_FLR]) |=> flr_o ##1 (s.ctrl.mrrs == MRRS_RESET);
	endproperty
	a_flr_pulse: assert property (p_flr_pulse) else $error("function reset not started");

	property p_err_sticky;
		@(posedge ref_clk_i) disable iff (rst_i)
		(s.err_sts.fatal && !(wr && cfg_req_i.be[2] && cfg_req_i.data[18])
			&& !link_reset_i && !s.flr) |=> s.err_sts.fatal;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag cleared without write");

	property p_unsup_set;
		@(posedge ref_clk_i) disable iff (rst_i)
		err_detect_i.unsup |=> s.err_sts.unsup;
	endproperty
	a_unsup_set: assert property (p_unsup_set) else $error("unsupported request not flagged");

	// Correctable flag must read at status bit 0, unsupported at bit 3
	property p_sts_order;
		@(posedge ref_clk_i) disable iff (rst_i)
		(hit && !cfg_req_i.write) |=> (cfg_rdata_o[16 + STS_ERR_LO] == $past(s.err_sts.corr))
			&& (cfg_rdata_o[16 + STS_ERR_LO + 3] == $past(s.err_sts.unsup));
	endproperty
	a_sts_order: assert property (p_sts_order) else $error("status bit order wrong");

	property p_msg_gated;
		@(posedge ref_clk_i) disable iff (rst_i)
		err_msg_o.corr |-> ($past(s.ctrl.err_rep[0]) && $past(err_detect_i.corr));
	endproperty
	a_msg_gated: assert property (p_msg_gated) else $error("message without enable");

	property p_pending_seen;
		@(posedge ref_clk_i) disable iff (rst_i)
		pending_i ##1 (hit && !cfg_req_i.write) |=> cfg_rdata_o[16 + STS_PENDING];
	endproperty
	a_pending_seen: assert property (p_pending_seen) else $error("pending not reported");

	c_flr:     cover property (@(posedge ref_clk_i) disable iff (rst_i) flr_o);
	c_w1c:     cover property (@(posedge ref_clk_i) disable iff (rst_i)
		s.err_sts.corr ##1 !s.err_sts.corr);
	c_rx_over: cover property (@(posedge ref_clk_i) disable iff (rst_i) rx_oversize_o);

endmodule
`default_nettype wire

// ### hdl/devctl_pkg.sv
// Shared constants and types for the device control and status register pair
package devctl_pkg;

	// ----------------------------------------------------------------
	// Configuration space layout
	// ----------------------------------------------------------------
	localparam logic [11:0] DEVICE_CONTROL_OFFSET = 12'h0a8;
	localparam logic [11:0] DEVICE_STATUS_OFFSET  = 12'h0aa;
	// Both halves live in the aligned dword at this address
	localparam logic [11:0] DEVCTL_DWORD_ADDR     = 12'h0a8;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CTL_ERR_LO   = 0;
	localparam int CTL_RO_EN    = 4;
	localparam int CTL_MPS_LO   = 5;
	localparam int CTL_EXT_TAG  = 8;
	localparam int CTL_PHANTOM  = 9;
	localparam int CTL_AUX_PM   = 10;
	localparam int CTL_NOSNOOP  = 11;
	localparam int CTL_MRRS_LO  = 12;
	localparam int CTL_FLR      = 15;

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int STS_ERR_LO   = 0;
	localparam int STS_AUX_DET  = 4;
	localparam int STS_PENDING  = 5;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [3:0] ERR_REP_RESET   = 4'h0;
	localparam logic       RO_EN_RESET     = 1'b1;
	localparam logic [2:0] MPS_RESET       = 3'h0;
	localparam logic       AUX_PM_RESET    = 1'b0;
	localparam logic       NOSNOOP_RESET   = 1'b1;
	localparam logic [2:0] MRRS_RESET      = 3'h2;
	localparam logic [2:0] MRRS_MAX_CODE   = 3'h3;
	localparam logic [2:0] MPS_CAP_DEFAULT = 3'h2;
	// Payload of code n is 128 << n bytes
	localparam int         SIZE_BASE_SHIFT = 7;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] data;
	} cfg_req_s;

	typedef struct packed {
		logic [2:0] mrrs;
		logic       nosnoop_en;
		logic       aux_pm;
		logic [2:0] mps;
		logic       ro_en;
		logic [3:0] err_rep;
	} ctrl_s;

	typedef struct packed {
		logic       corr;
		logic       nonfatal;
		logic       fatal;
		logic       unsup;
	} err_s;

endpackage

// ### hdl/level_sync.sv
// Two flip-flop synchroniser for slow level inputs
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	// Levels
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} sync_state_s;

	sync_state_s s;
	sync_state_s next_s;

	// First stage feeds only the second
	always_comb begin
		next_s.meta = async_i;
		next_s.held = s.meta;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_o = s.held;

endmodule
`default_nettype wire

// ### tb/host_cfg_model.sv
// Host configuration requester model for the config port
`timescale 1ns/1ns
`default_nettype none
module host_cfg_model #(
	parameter logic [2:0] MPS_CAP = 3'h2
) (
	// Clock
	input  wire logic            ref_clk_i,
	// Config port
	output devctl_pkg::cfg_req_s cfg_req_o,
	input  wire logic            cfg_ack_i,
	input  wire logic [31:0]     cfg_rdata_i
);
	import devctl_pkg::*;

	initial cfg_req_o = '0;

	// One access; the request stands a single cycle, then the lines are scrambled
	task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
		input logic [31:0] data, input logic raw, output logic [31:0] rdata);
		int n;
		n = 0;
		// Software keeps payload within the advertised limit unless told otherwise
		if (!raw && wr && be[0] && data[7:5] > MPS_CAP) data[7:5] = MPS_CAP;
		@(posedge ref_clk_i);
		cfg_req_o <= '{1'b1, wr, addr, be, data};
		@(posedge ref_clk_i);
		cfg_req_o <= '{1'b0, ~wr, ~addr, ~be, ~data};
		@(negedge ref_clk_i);
		while (cfg_ack_i !== 1'b1 && n < 8) begin
			@(negedge ref_clk_i);
			n++;
		end
		rdata = (cfg_ack_i === 1'b1) ? cfg_rdata_i : 32'hxxxxxxxx;
	endtask
endmodule
`default_nettype wire

// ### tb/pcie_device_control_status_tb_top.sv
// Self-checking bench for the device control and status registers
`timescale 1ns/1ns
`default_nettype none
module pcie_device_control_status_tb_top;
	import devctl_pkg::*;
	localparam logic [2:0] CAP = 3'h2;

	// Stimulus and observed signals
	logic        ref_clk_i    = 1'b0;
	logic        rst_i        = 1'b1;
	logic        link_reset_i = 1'b0;
	cfg_req_s    cfg_req;
	logic        cfg_ack;
	logic [31:0] cfg_rdata;
	err_s        err_detect   = '0;
	logic        pending      = 1'b0;
	logic        relaxed_order_disable       = 1'b0;
	logic [1:0]  gate         = 2'h3;
	logic        rx_valid     = 1'b0;
	logic [12:0] rx_len       = '0;
	logic        strap        = 1'b0;
	ctrl_s       ctrl;
	logic        ro_ok;
	logic        flr;
	logic [1:0]  ns_ok;
	err_s        err_msg;
	logic        oversize;
	int          num_errors   = 0;
	int          compares     = 0;
	logic [31:0] rd;

	// 50 MHz clock
	always #10 ref_clk_i = ~ref_clk_i;

	pcie_device_control_status #(.MPS_CAP(CAP)) i_dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link_reset_i(link_reset_i),
		.cfg_req_i(cfg_req), .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata),
		.err_detect_i(err_detect), .pending_i(pending),
		.relaxed_order_disable_i(relaxed_order_disable), .nosnoop_gate_bits_i(gate),
		.rx_valid_i(rx_valid), .rx_len_i(rx_len), .aux_power_strap_i(strap),
		.ctrl_o(ctrl), .relaxed_order_ok_o(ro_ok), .nosnoop_ok_o(ns_ok),
		.flr_o(flr), .err_msg_o(err_msg), .rx_oversize_o(oversize)
	);

	host_cfg_model #(.MPS_CAP(CAP)) i_host (
		.ref_clk_i(ref_clk_i), .cfg_req_o(cfg_req),
		.cfg_ack_i(cfg_ack), .cfg_rdata_i(cfg_rdata)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] be, input logic [31:0] d, input logic raw = 1'b0);
		i_host.access(1'b1, DEVCTL_DWORD_ADDR, be, d, raw, rd);
	endtask

	task automatic rdreg(input logic [11:0] a);
		i_host.access(1'b0, a, 4'hf, 32'h0, 1'b0, rd);
	endtask

	// Register bit order is corr, nonfatal, fatal, unsup from bit 0 up
	function automatic err_s doc_err(input logic [3:0] v);
		return '{corr: v[0], nonfatal: v[1], fatal: v[2], unsup: v[3]};
	endfunction

	function automatic logic [3:0] err_doc(input err_s e);
		return {e.unsup, e.fatal, e.nonfatal, e.corr};
	endfunction

	task automatic finish_test();
		$display("Mismatches %0d, comparisons %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog far beyond the hundred or fewer cycles the sequence needs
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		num_errors++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rdreg(DEVCTL_DWORD_ADDR);
		check(rd, 32'h0000_2810, "reset values");
		rdreg(12'h0ac);
		check(rd, 32'h0, "unmapped read");
		// Oversize payload and reserved read size are ignored, bits 8 and 9 stay zero
		wr(4'h3, 32'h0000_7fff, 1'b1);
		rdreg(DEVCTL_DWORD_ADDR);
		check(rd, 32'h0000_2c1f, "refused fields");
		wr(4'h3, 32'h0000_3c5f);
		rdreg(DEVCTL_DWORD_ADDR);
		check(rd, 32'h0000_3c5f, "full write");
		check(ctrl, 32'h0000_0f5f, "control outputs");
		// Permission outputs against every disable and gate setting
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk_i);
			relaxed_order_disable <= i[2];
			gate <= i[1:0];
			@(posedge ref_clk_i);
			@(negedge ref_clk_i);
			check(ro_ok, !i[2], "relaxed order");
			check(ns_ok, i[1:0], "no snoop");
		end
		wr(4'h3, 32'h0000_344f);
		@(posedge ref_clk_i);
		relaxed_order_disable <= 1'b0;
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check(ro_ok, 1'b0, "relaxed order off");
		check(ns_ok, 2'h0, "no snoop off");
		// Payload limit of 512 bytes at code 2
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk_i);
			rx_valid <= 1'b1;
			rx_len <= 13'(512 + i);
			@(posedge ref_clk_i);
			rx_valid <= 1'b0;
			@(negedge ref_clk_i);
			check(oversize, i, "oversize");
		end
		// Function level reset keeps payload size and the sticky aux enable
		wr(4'h3, 32'h0000_b44f);
		check(flr, 1'b1, "flr pulse");
		rdreg(DEVCTL_DWORD_ADDR);
		check(flr, 1'b0, "flr single");
		check(rd, 32'h0000_2c50, "after flr");
		// Errors set status always, messages only where enabled
		wr(4'h3, 32'h0000_2c55);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			err_detect <= doc_err(4'(1 << i));
			@(posedge ref_clk_i);
			err_detect <= '0;
			@(negedge ref_clk_i);
			check(err_doc(err_msg), 4'(1 << i) & 4'h5, "message");
		end
		rdreg(DEVCTL_DWORD_ADDR);
		check(rd, 32'h000f_2c55, "error status");
		wr(4'h4, 32'h0005_0000);
		rdreg(DEVCTL_DWORD_ADDR);
		check(rd, 32'h000a_2c55, "write one clear");
		// Strap and pending levels, then an ordinary reset
		@(posedge ref_clk_i);
		pending <= 1'b1;
		strap <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rdreg(DEVCTL_DWORD_ADDR);
		check(rd[31:16], 16'h003a, "strap pending");
		@(posedge ref_clk_i);
		link_reset_i <= 1'b1;
		pending <= 1'b0;
		@(posedge ref_clk_i);
		link_reset_i <= 1'b0;
		rdreg(DEVCTL_DWORD_ADDR);
		check(rd, 32'h0010_2c10, "link reset");
		// Power-good reset clears the sticky enable
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		@(negedge ref_clk_i);
		check(ctrl.aux_pm, 1'b0, "sticky cleared");
		@(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		rdreg(DEVCTL_DWORD_ADDR);
		check(rd, 32'h0010_2810, "after power reset");
		finish_test();
	end
endmodule
`default_nettype wire
